// File: nvm_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the controller
`ifndef NVM_CTRL_REGS_SVH
`define NVM_CTRL_REGS_SVH

`define OFS_COMMAND_CONTROL  4'h0
`define OFS_LOCK_CONTROL     4'h1
`define OFS_OPERATION_STATUS 4'h2
`define OFS_INTERRUPT_ENABLE 4'h3
`define OFS_INTERRUPT_FLAGS  4'h4
`define OFS_RESERVED         4'h5
`define OFS_DATA_LO          4'h6
`define OFS_DATA_HI          4'h7
`define OFS_ADDR_LO          4'h8
`define OFS_ADDR_HI          4'h9

`define CMD_MSB              2
`define CMD_LSB              0
`define LOCK_APP_BIT         0
`define LOCK_BOOT_BIT        1
`define STAT_FLASH_BIT       0
`define STAT_EE_BIT          1
`define STAT_FAULT_BIT       2
`define INT_READY_BIT        0

`define RST_BYTE             8'h00
`define RST_WORD             16'h0000

// Operation durations in core clock cycles; key window in register writes
`define T_PAGE_OP            16'h0040
`define T_BUF_CLEAR          16'h0007
`define T_FULL_ERASE         16'h0100
`define T_FUSE_OP            16'h0020
`define KEY_WINDOW           3'h4

`endif

// File: nvm_ctrl_pkg.sv
// Types shared by the controller files
package nvm_ctrl_pkg;
  typedef enum logic [2:0] {
    CMD_NONE        = 3'h0,
    CMD_PAGE_WRITE  = 3'h1,
    CMD_PAGE_ERASE  = 3'h2,
    CMD_ERASE_PROG  = 3'h3,
    CMD_BUF_CLEAR   = 3'h4,
    CMD_FULL_ERASE  = 3'h5,
    CMD_EE_ERASE    = 3'h6,
    CMD_FUSE_PROG   = 3'h7
  } nvm_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_BUSY  = 4'b1000
  } nvm_state_e;
endpackage : nvm_ctrl_pkg

// File: nvm_op_timer.sv
// Down counter that times one array operation
`include "nvm_ctrl_regs.svh"
module nvm_op_timer (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] count,
  output logic             done
);
  logic [15:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= `RST_WORD;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != `RST_WORD) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  assign done = (cnt_q == 16'h0001);
endmodule : nvm_op_timer

// File: nvm_controller_registers.sv
// Nonvolatile memory controller register block with command sequencer
`include "nvm_ctrl_regs.svh"

// Rules of the document this block is built on
// R1: Nonzero command field write starts an operation
// R2: Key written within four instructions before command; the code counts four register writes instead
// R3: Code 1 writes page, code 2 erases page
// R4: Code 3 erase then write; 4 clears buffer
// R5: Code 5 full erase, preserve fuse spares EEPROM
// R6: Code 6 erases EEPROM; 7 debug port only
// R7: Boot lock blocks reads and fetches of boot
// R8: Locked boot reads and fetches return zero
// R9: Boot lock set from boot only, reset clears
// R10: Boot lock effective after first boot exit
// R11: Application protect blocks application section writes
// R12: Application protect set-only, reset clears
// R13: Write fault bit set after failed write
// R14: Write fault reflects only most recent operation
// R15: EEPROM busy reads one while EEPROM works
// R16: Flash busy reads one while flash works
// R17: Interrupt enable bit 0 gates ready level
// R18: Software enables interrupt only after issuing command
// R19: Ready flag set every cycle EEPROM idle
// R20: Write one clears ready flag, zero ignored
// R21: Low byte at base, high byte next
// R22: Data register holds debug port fuse value
// R23: Address register holds last updated location
// R24: Interrupt asserted while flag and enable set
// R25: Unkeyed command write leaves register unchanged
// R26: Reserved bits and offset read zero
module nvm_controller_registers (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        self_program_key,
  input  wire logic        debug_programming_port,
  input  wire logic        exec_in_boot,
  input  wire logic        target_is_eeprom,
  input  wire logic        target_in_boot,
  input  wire logic        target_in_app,
  input  wire logic        buffer_mixed,
  input  wire logic        eeprom_preserve_fuse,
  input  wire logic        boot_access,
  input  wire logic [15:0] array_rdata,
  output logic [15:0]      fetch_rdata,
  output logic             flash_busy,
  output logic             eeprom_busy,
  output logic             array_erase,
  output logic             array_program,
  output logic             buffer_clear,
  output logic             full_erase,
  output logic             eeprom_full_erase,
  output logic             fuse_program,
  output logic             irq
);

  logic [2:0]              cmd_q;
  logic [2:0]              key_cnt_q;
  logic                    app_write_protect_q;
  logic                    boot_lock_pend_q;
  logic                    boot_section_lock_q;
  logic                    write_fault_q;
  logic                    int_en_q;
  logic                    eeprom_ready_q;
  logic [15:0]             data_q;
  logic [15:0]             addr_q;
  logic                    op_ee_q;
  logic                    op_flash_q;
  nvm_ctrl_pkg::nvm_state_e state_q;
  nvm_ctrl_pkg::nvm_state_e state_d;
  logic                    start;
  logic                    refused;
  logic                    tmr_load;
  logic [15:0]             tmr_count;
  logic                    tmr_done;
  logic                    exec_in_boot_q;

  function automatic logic wr_at(input logic [3:0] ofs);
    wr_at = reg_wr && (reg_addr == ofs);
  endfunction : wr_at

  // Key window counts register writes; it stands in for four instructions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      key_cnt_q <= 3'h0;
    end else if (self_program_key) begin
      key_cnt_q <= `KEY_WINDOW;
    end else if (reg_wr && key_cnt_q != 3'h0) begin
      key_cnt_q <= key_cnt_q - 3'h1;
    end
  end

  // Command accepted only if keyed, idle and nonzero
  assign start = wr_at(`OFS_COMMAND_CONTROL) && (key_cnt_q != 3'h0) // R2 R25
                 && (reg_wdata[`CMD_MSB:`CMD_LSB] != nvm_ctrl_pkg::CMD_NONE) // R1
                 && (state_q == nvm_ctrl_pkg::ST_IDLE);

  // Protected or mixed targets are refused and flagged
  always_comb begin
    refused = 1'b0;
    case (nvm_ctrl_pkg::nvm_cmd_e'(reg_wdata[`CMD_MSB:`CMD_LSB]))
      nvm_ctrl_pkg::CMD_PAGE_WRITE,
      nvm_ctrl_pkg::CMD_PAGE_ERASE,
      nvm_ctrl_pkg::CMD_ERASE_PROG: begin
        refused = buffer_mixed // R13
                  || (app_write_protect_q && target_in_app) // R11
                  || (boot_section_lock_q && target_in_boot);
      end
      nvm_ctrl_pkg::CMD_FUSE_PROG: begin
        refused = !debug_programming_port; // R6
      end
      default: begin
        refused = 1'b0;
      end
    endcase
  end

  // Only a command that runs is shown; a refused one must not linger in the field
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_q <= 3'h0;
    end else if (start && !refused) begin
      cmd_q <= reg_wdata[`CMD_MSB:`CMD_LSB]; // R1
    end else if (state_q != nvm_ctrl_pkg::ST_IDLE && state_d == nvm_ctrl_pkg::ST_IDLE) begin
      cmd_q <= 3'h0;
    end
  end

  // Each started command overwrites the fault bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_fault_q <= 1'b0;
    end else if (start) begin
      write_fault_q <= refused; // R13 R14
    end
  end

  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_count = `RST_WORD;
    case (state_q)
      nvm_ctrl_pkg::ST_IDLE: begin
        if (start && !refused) begin
          tmr_load = 1'b1;
          case (nvm_ctrl_pkg::nvm_cmd_e'(reg_wdata[`CMD_MSB:`CMD_LSB]))
            nvm_ctrl_pkg::CMD_PAGE_WRITE: begin
              state_d   = nvm_ctrl_pkg::ST_WRITE; // R3
              tmr_count = `T_PAGE_OP;
            end
            nvm_ctrl_pkg::CMD_PAGE_ERASE,
            nvm_ctrl_pkg::CMD_ERASE_PROG: begin
              state_d   = nvm_ctrl_pkg::ST_ERASE; // R3 R4
              tmr_count = `T_PAGE_OP;
            end
            nvm_ctrl_pkg::CMD_BUF_CLEAR: begin
              state_d   = nvm_ctrl_pkg::ST_BUSY; // R4
              tmr_count = `T_BUF_CLEAR;
            end
            nvm_ctrl_pkg::CMD_FUSE_PROG: begin
              state_d   = nvm_ctrl_pkg::ST_BUSY;
              tmr_count = `T_FUSE_OP;
            end
            default: begin
              state_d   = nvm_ctrl_pkg::ST_BUSY; // R5 R6
              tmr_count = `T_FULL_ERASE;
            end
          endcase
        end
      end
      nvm_ctrl_pkg::ST_ERASE: begin
        if (tmr_done) begin
          if (cmd_q == nvm_ctrl_pkg::CMD_ERASE_PROG) begin
            state_d   = nvm_ctrl_pkg::ST_WRITE; // R4
            tmr_load  = 1'b1;
            tmr_count = `T_PAGE_OP;
          end else begin
            state_d = nvm_ctrl_pkg::ST_IDLE;
          end
        end
      end
      nvm_ctrl_pkg::ST_WRITE,
      nvm_ctrl_pkg::ST_BUSY: begin
        if (tmr_done) begin
          state_d = nvm_ctrl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = nvm_ctrl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= nvm_ctrl_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Which array the running command occupies
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_ee_q    <= 1'b0;
      op_flash_q <= 1'b0;
    end else if (start && !refused) begin
      case (nvm_ctrl_pkg::nvm_cmd_e'(reg_wdata[`CMD_MSB:`CMD_LSB]))
        nvm_ctrl_pkg::CMD_FULL_ERASE: begin
          op_flash_q <= 1'b1;
          op_ee_q    <= !eeprom_preserve_fuse; // R5
        end
        nvm_ctrl_pkg::CMD_EE_ERASE: begin
          op_flash_q <= 1'b0;
          op_ee_q    <= 1'b1; // R6
        end
        nvm_ctrl_pkg::CMD_BUF_CLEAR,
        nvm_ctrl_pkg::CMD_FUSE_PROG: begin
          op_flash_q <= 1'b1;
          op_ee_q    <= 1'b0;
        end
        default: begin
          op_flash_q <= !target_is_eeprom;
          op_ee_q    <= target_is_eeprom;
        end
      endcase
    end
  end

  nvm_op_timer u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (tmr_load),
    .count    (tmr_count),
    .done     (tmr_done)
  );

  assign flash_busy  = (state_q != nvm_ctrl_pkg::ST_IDLE) && op_flash_q; // R16
  assign eeprom_busy = (state_q != nvm_ctrl_pkg::ST_IDLE) && op_ee_q; // R15

  assign array_erase       = (state_q == nvm_ctrl_pkg::ST_ERASE); // R3
  assign array_program     = (state_q == nvm_ctrl_pkg::ST_WRITE); // R3
  assign buffer_clear      = (state_q == nvm_ctrl_pkg::ST_BUSY)
                             && (cmd_q == nvm_ctrl_pkg::CMD_BUF_CLEAR); // R4
  assign full_erase        = (state_q == nvm_ctrl_pkg::ST_BUSY)
                             && (cmd_q == nvm_ctrl_pkg::CMD_FULL_ERASE); // R5
  assign eeprom_full_erase = (state_q == nvm_ctrl_pkg::ST_BUSY)
                             && ((cmd_q == nvm_ctrl_pkg::CMD_EE_ERASE)
                             || (cmd_q == nvm_ctrl_pkg::CMD_FULL_ERASE && op_ee_q)); // R5 R6
  assign fuse_program      = (state_q == nvm_ctrl_pkg::ST_BUSY)
                             && (cmd_q == nvm_ctrl_pkg::CMD_FUSE_PROG); // R6

  // Protect bit is sticky: zero writes are ignored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      app_write_protect_q <= 1'b0;
    end else if (wr_at(`OFS_LOCK_CONTROL) && reg_wdata[`LOCK_APP_BIT]) begin
      app_write_protect_q <= 1'b1; // R12
    end
  end

  // Boot lock is armed on a write made from boot and acts once execution leaves boot
  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_lock_pend_q    <= 1'b0;
      boot_section_lock_q <= 1'b0;
      exec_in_boot_q      <= 1'b0;
    end else begin
      exec_in_boot_q <= exec_in_boot;
      if (wr_at(`OFS_LOCK_CONTROL) && reg_wdata[`LOCK_BOOT_BIT] && exec_in_boot) begin
        boot_lock_pend_q <= 1'b1; // R9
      end
      if (boot_lock_pend_q && exec_in_boot_q && !exec_in_boot) begin
        boot_section_lock_q <= 1'b1; // R10
      end
    end
  end

  // Locked boot data and instructions read as zero; path is combinational
  assign fetch_rdata = (boot_section_lock_q && boot_access) ? `RST_WORD : array_rdata; // R7 R8

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_en_q <= 1'b0;
    end else if (wr_at(`OFS_INTERRUPT_ENABLE)) begin
      int_en_q <= reg_wdata[`INT_READY_BIT]; // R17
    end
  end

  // Idle EEPROM sets the flag each cycle; set wins over a clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eeprom_ready_q <= 1'b0;
    end else if (!eeprom_busy) begin
      eeprom_ready_q <= 1'b1; // R19
    end else if (wr_at(`OFS_INTERRUPT_FLAGS) && reg_wdata[`INT_READY_BIT]) begin
      eeprom_ready_q <= 1'b0; // R20
    end
  end

  assign irq = eeprom_ready_q && int_en_q; // R24

  // Data and address byte halves
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_q <= `RST_WORD;
      addr_q <= `RST_WORD;
    end else begin
      if (wr_at(`OFS_DATA_LO)) data_q[7:0]  <= reg_wdata; // R21 R22
      if (wr_at(`OFS_DATA_HI)) data_q[15:8] <= reg_wdata; // R21 R22
      if (wr_at(`OFS_ADDR_LO)) addr_q[7:0]  <= reg_wdata; // R21 R23
      if (wr_at(`OFS_ADDR_HI)) addr_q[15:8] <= reg_wdata; // R21 R23
    end
  end

  // Read data lasts one cycle and falls back to zero, so stale values never linger
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_COMMAND_CONTROL:  reg_rdata <= {5'h00, cmd_q};
        `OFS_LOCK_CONTROL:     reg_rdata <= {6'h00, boot_lock_pend_q, app_write_protect_q};
        `OFS_OPERATION_STATUS: reg_rdata <= {5'h00, write_fault_q, eeprom_busy, flash_busy};
        `OFS_INTERRUPT_ENABLE: reg_rdata <= {7'h00, int_en_q};
        `OFS_INTERRUPT_FLAGS:  reg_rdata <= {7'h00, eeprom_ready_q};
        `OFS_DATA_LO:          reg_rdata <= data_q[7:0];
        `OFS_DATA_HI:          reg_rdata <= data_q[15:8];
        `OFS_ADDR_LO:          reg_rdata <= addr_q[7:0];
        `OFS_ADDR_HI:          reg_rdata <= addr_q[15:8];
        default:               reg_rdata <= `RST_BYTE; // R26
      endcase
    end else begin
      reg_rdata <= `RST_BYTE;
    end
  end
endmodule : nvm_controller_registers

// File: nvm_regs_chk.sv
// Port assertions for the nonvolatile controller register block
module nvm_regs_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        self_program_key,
  input wire logic        boot_access,
  input wire logic [15:0] array_rdata,
  input wire logic [15:0] fetch_rdata,
  input wire logic        flash_busy,
  input wire logic        eeprom_busy,
  input wire logic        buffer_clear,
  input wire logic        full_erase,
  input wire logic        fuse_program,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Key window and enable rebuilt from bus traffic, since the body is hidden
  logic [2:0] win_q;
  logic       en_q;
  always_ff @(posedge core_clk) begin
    if (rst)
      win_q <= 3'h0;
    else if (self_program_key)
      win_q <= 3'h4;
    else if (reg_wr && win_q != 3'h0)
      win_q <= win_q - 3'h1;
  end
  always_ff @(posedge core_clk) begin
    if (rst)
      en_q <= 1'b0;
    else if (reg_wr && reg_addr == 4'h3)
      en_q <= reg_wdata[0];
  end
  no_start_a: assert property (reg_wr && reg_addr == 4'h0 &&
    (win_q == 3'h0 || reg_wdata[2:0] == 3'h0) |=> !$rose(flash_busy) && !$rose(eeprom_busy))
    else $error("command started without key or with code zero");
  clear_len_a: assert property ($rose(buffer_clear) |-> buffer_clear [*7] ##1 !buffer_clear)
    else $error("buffer clear length wrong");
  fuse_len_a: assert property ($rose(fuse_program) |-> ##31 fuse_program ##1 !fuse_program)
    else $error("fuse program length wrong");
  erase_len_a: assert property ($rose(full_erase) |-> ##255 full_erase ##1 !full_erase)
    else $error("full erase length wrong");
  fetch_lock_a: assert property (fetch_rdata != array_rdata |->
    boot_access && fetch_rdata == 16'h0000)
    else $error("fetch data altered outside a locked boot access");
  irq_level_a: assert property (en_q && !$past(eeprom_busy) |-> irq)
    else $error("interrupt missing while ready and enabled");
  irq_mask_a: assert property (!en_q |-> !irq)
    else $error("interrupt while disabled");
  rsvd_zero_a: assert property ($past(reg_rd) &&
    ($past(reg_addr) == 4'h5 || $past(reg_addr) > 4'h9) |-> reg_rdata == 8'h00)
    else $error("reserved offset read nonzero");
endmodule : nvm_regs_chk

// File: nvm_array_model.sv
// Array read side: data that never reads zero and moves every cycle
module nvm_array_model (
  input  wire logic   core_clk,
  output logic [15:0] array_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Top bit held high so a zeroed fetch can never pass as a match
  initial array_rdata = 16'h8001;
  always @(posedge core_clk) array_rdata <= {1'b1, array_rdata[14:0] + 15'h0123};
endmodule : nvm_array_model

// File: tb.sv
// Self-checking bench for the nonvolatile controller register block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        self_program_key = 1'b0, debug_programming_port = 1'b0;
  logic        exec_in_boot = 1'b0, target_is_eeprom = 1'b0, target_in_boot = 1'b0;
  logic        target_in_app = 1'b0, buffer_mixed = 1'b0, eeprom_preserve_fuse = 1'b0;
  logic        boot_access = 1'b0, flash_busy, eeprom_busy, array_erase, array_program;
  logic        buffer_clear, full_erase, eeprom_full_erase, fuse_program, irq;
  logic [15:0] array_rdata, fetch_rdata;
  int          errors = 0;
  int          check_count = 0;
  always #10 core_clk = ~core_clk;
  nvm_array_model arr (.core_clk(core_clk), .array_rdata(array_rdata));
  nvm_controller_registers uut (
    .core_clk               (core_clk),
    .rst                    (rst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .self_program_key       (self_program_key),
    .debug_programming_port (debug_programming_port),
    .exec_in_boot           (exec_in_boot),
    .target_is_eeprom       (target_is_eeprom),
    .target_in_boot         (target_in_boot),
    .target_in_app          (target_in_app),
    .buffer_mixed           (buffer_mixed),
    .eeprom_preserve_fuse   (eeprom_preserve_fuse),
    .boot_access            (boot_access),
    .array_rdata            (array_rdata),
    .fetch_rdata            (fetch_rdata),
    .flash_busy             (flash_busy),
    .eeprom_busy            (eeprom_busy),
    .array_erase            (array_erase),
    .array_program          (array_program),
    .buffer_clear           (buffer_clear),
    .full_erase             (full_erase),
    .eeprom_full_erase      (eeprom_full_erase),
    .fuse_program           (fuse_program),
    .irq                    (irq)
  );
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t pin %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the following cycle, so it is sampled mid-cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk8(reg_rdata, exp);
  endtask : rd
  task automatic key_pulse;
    @(posedge core_clk);
    self_program_key <= 1'b1;
    @(posedge core_clk);
    self_program_key <= 1'b0;
  endtask : key_pulse
  task automatic cmd(input logic [2:0] c);
    key_pulse();
    wr(4'h0, {5'h00, c});
  endtask : cmd
  task automatic idle_wait;
    int n;
    n = 0;
    @(negedge core_clk);
    while ((flash_busy || eeprom_busy) && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk1(n < 400, 1'b1);
  endtask : idle_wait
  task automatic t_reset_vals;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], (a == 4) ? 8'h01 : 8'h00);
    end
  endtask : t_reset_vals
  task automatic t_bytes;
    logic [3:0] ad [7] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'h5, 4'h3, 4'h2};
    logic [7:0] wd [7] = '{8'h5a, 8'hc3, 8'h3c, 8'h96, 8'hff, 8'hfe, 8'hff};
    logic [7:0] ex [7] = '{8'h5a, 8'hc3, 8'h3c, 8'h96, 8'h00, 8'h00, 8'h00};
    foreach (ad[i]) wr(ad[i], wd[i]);
    foreach (ad[i]) rd(ad[i], ex[i]);
  endtask : t_bytes
  task automatic t_key;
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    key_pulse();
    repeat (4) wr(4'h6, 8'h11);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    key_pulse();
    repeat (3) wr(4'h6, 8'h22);
    wr(4'h0, 8'h04);
    rd(4'h0, 8'h04);
    idle_wait();
  endtask : t_key
  task automatic t_cmds;
    for (int c = 1; c < 7; c++) begin
      @(posedge core_clk);
      target_is_eeprom <= (c == 2 || c == 6);
      eeprom_preserve_fuse <= (c == 5);
      cmd(c[2:0]);
      rd(4'h0, {5'h00, c[2:0]});
      chk1((c == 2 || c == 6) ? eeprom_busy : flash_busy, 1'b1);
      chk1(array_erase, c == 2 || c == 3);
      chk1(array_program, c == 1);
      chk1(eeprom_full_erase, c == 6);
      idle_wait();
      rd(4'h2, 8'h00);
    end
    @(posedge core_clk);
    eeprom_preserve_fuse <= 1'b0;
    cmd(3'h5);
    rd(4'h0, 8'h05);
    chk1(eeprom_full_erase & eeprom_busy & full_erase, 1'b1);
    idle_wait();
    cmd(3'h7);
    rd(4'h2, 8'h04);
    rd(4'h0, 8'h00);
    @(posedge core_clk);
    debug_programming_port <= 1'b1;
    cmd(3'h7);
    rd(4'h0, 8'h07);
    idle_wait();
    rd(4'h2, 8'h00);
  endtask : t_cmds
  task automatic t_irq;
    cmd(3'h6);
    wr(4'h3, 8'h01);
    @(negedge core_clk);
    chk1(irq, 1'b1);
    wr(4'h4, 8'h01);
    @(negedge core_clk);
    chk1(irq, 1'b0);
    wr(4'h4, 8'h00);
    @(negedge core_clk);
    chk1(irq, 1'b0);
    idle_wait();
    @(negedge core_clk);
    chk1(irq, 1'b1);
    wr(4'h3, 8'h00);
    @(negedge core_clk);
    chk1(irq, 1'b0);
  endtask : t_irq
  task automatic t_protect;
    wr(4'h1, 8'h01);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h01);
    @(posedge core_clk);
    target_in_app <= 1'b1;
    cmd(3'h1);
    rd(4'h2, 8'h04);
    chk1(flash_busy, 1'b0);
    rd(4'h0, 8'h00);
    @(posedge core_clk);
    target_in_app <= 1'b0;
    cmd(3'h4);
    idle_wait();
    rd(4'h2, 8'h00);
    @(posedge core_clk);
    buffer_mixed <= 1'b1;
    cmd(3'h1);
    rd(4'h2, 8'h04);
    @(posedge core_clk);
    buffer_mixed <= 1'b0;
    cmd(3'h4);
    idle_wait();
    rd(4'h2, 8'h00);
  endtask : t_protect
  task automatic t_boot;
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h01);
    @(posedge core_clk);
    exec_in_boot <= 1'b1;
    boot_access <= 1'b1;
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h03);
    chk1(fetch_rdata === array_rdata, 1'b1);
    @(posedge core_clk);
    exec_in_boot <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk1(fetch_rdata === 16'h0000, 1'b1);
    @(posedge core_clk);
    boot_access <= 1'b0;
    @(negedge core_clk);
    chk1(fetch_rdata === array_rdata, 1'b1);
    @(posedge core_clk);
    target_in_boot <= 1'b1;
    cmd(3'h2);
    rd(4'h2, 8'h04);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h1, 8'h00);
  endtask : t_boot
  task automatic final_report;
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_vals();
    t_bytes();
    t_key();
    t_cmds();
    t_irq();
    t_protect();
    t_boot();
    final_report();
  end
  // Whole run is under two thousand cycles; this cuts a hang short
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule : tb

bind nvm_controller_registers nvm_regs_chk chk (
  .core_clk         (core_clk),
  .rst              (rst),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_wr           (reg_wr),
  .reg_rd           (reg_rd),
  .reg_rdata        (reg_rdata),
  .self_program_key (self_program_key),
  .boot_access      (boot_access),
  .array_rdata      (array_rdata),
  .fetch_rdata      (fetch_rdata),
  .flash_busy       (flash_busy),
  .eeprom_busy      (eeprom_busy),
  .buffer_clear     (buffer_clear),
  .full_erase       (full_erase),
  .fuse_program     (fuse_program),
  .irq              (irq)
);
